// >>> gpo_top.sv
`timescale 1ns/1ps
`include "gpo_defs.svh"
module gpo_top #(
  parameter int NUM_OUT = 2,
  parameter int NUM_IN = 2,
  parameter int NUM_PINS = 4,
  parameter int TICK_CYCLES = `GPO_MS_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_OUT-1:0] trig_in,
  input wire logic [NUM_PINS-1:0] pin_in,
  output logic [NUM_PINS-1:0] pin_out,
  output logic [NUM_PINS-1:0] pin_oe_n,
  output logic irq
);
  import gpo_pkg::*;

  localparam int SEL_W = (NUM_PINS > 1) ? $clog2(NUM_PINS) : 1;
  localparam int EV_W = NUM_OUT + NUM_IN;
  localparam int TICK_W = $clog2(TICK_CYCLES + 1);

  // ==========================================================
  // Declarations
  logic [15:0] hold_ms [NUM_OUT];
  logic rest_level [NUM_OUT];
  logic report_en [NUM_OUT];
  logic [SEL_W-1:0] out_pin_sel [NUM_OUT];
  logic [SEL_W-1:0] in_pin_sel [NUM_IN];
  logic [NUM_IN-1:0] in_level;
  logic [NUM_IN-1:0] in_sample;
  logic [NUM_OUT-1:0] active;
  logic [NUM_OUT-1:0] changed;
  logic [NUM_OUT-1:0] lvl;
  logic [NUM_OUT-1:0] trig_prev;
  logic [NUM_OUT-1:0] trig_edge;
  logic [NUM_OUT-1:0] sw_trig;
  logic [NUM_OUT-1:0] chan_trig;
  logic [EV_W-1:0] int_stat;
  logic [EV_W-1:0] int_mask;
  logic [EV_W-1:0] ev_all;
  logic [EV_W-1:0] w1c;
  logic [TICK_W-1:0] tick_cnt;
  logic ms_tick;
  logic setup;
  logic wr;
  logic hit;
  logic [31:0] rd_val;
  logic [NUM_PINS-1:0] next_pin_out;
  logic [NUM_PINS-1:0] next_oe_n;

  // ==========================================================
  // Millisecond timebase
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_cnt <= '0;
    end else if (ce) begin
      if (ms_tick) begin
        tick_cnt <= '0;
      end else begin
        tick_cnt <= tick_cnt + 1'b1;
      end
    end
  end

  assign ms_tick = (tick_cnt == TICK_W'(TICK_CYCLES - 1));

  // ==========================================================
  // Trigger edges
  // A source held high gives one trigger only, so a long press on a
  // pulsed channel cannot start a second pulse
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trig_prev <= '0;
    end else if (ce) begin
      trig_prev <= trig_in;
    end
  end

  assign trig_edge = trig_in & ~trig_prev;
  assign chan_trig = trig_edge | sw_trig;

  // ==========================================================
  // Output channels
  for (genvar i = 0; i < NUM_OUT; i++) begin : g_out
    gpo_channel #(
      .HOLD_W(16)
    ) u_chan (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .ms_tick(ms_tick),
      .trig(chan_trig[i]),
      .hold_ms(hold_ms[i]),
      .state(),
      .active(active[i]),
      .changed(changed[i])
    );
    assign lvl[i] = rest_level[i] ^ active[i];
  end

  // ==========================================================
  // Pin drive
  // Several channels may share a pin; the lowest index wins
  always_comb begin
    next_pin_out = '0;
    next_oe_n = '1;
    for (int i = NUM_OUT - 1; i >= 0; i--) begin
      next_pin_out[out_pin_sel[i]] = lvl[i];
      next_oe_n[out_pin_sel[i]] = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_out <= '0;
      pin_oe_n <= '1;
    end else if (ce) begin
      pin_out <= next_pin_out;
      pin_oe_n <= next_oe_n;
    end
  end

  // ==========================================================
  // Input channels
  // A pin also driven by an output reads back our own level
  for (genvar j = 0; j < NUM_IN; j++) begin : g_in
    assign in_sample[j] = pin_in[in_pin_sel[j]];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      in_level <= '0;
    end else if (ce) begin
      in_level <= in_sample;
    end
  end

  // ==========================================================
  // APB slave
  // No wait state: pready rises in the first access cycle
  assign setup = psel && !penable;
  assign wr = psel && penable && pready && pwrite;

  always_comb begin
    rd_val = '0;
    hit = 1'b0;
    for (int i = 0; i < NUM_OUT; i++) begin
      if (paddr == `GPO_OUT_CFG_BASE + 8'(4 * i)) begin
        hit = 1'b1;
        rd_val[`GPO_F_HOLD +: 16] = hold_ms[i];
        rd_val[`GPO_F_REST] = rest_level[i];
        rd_val[`GPO_F_REPORT] = report_en[i];
        rd_val[`GPO_F_PIN +: SEL_W] = out_pin_sel[i];
        rd_val[`GPO_F_INDEX +: 4] = 4'(i);
        rd_val[`GPO_F_TYPE +: 4] = `GPO_TYPE_OUT;
      end
    end
    for (int j = 0; j < NUM_IN; j++) begin
      if (paddr == `GPO_IN_CFG_BASE + 8'(4 * j)) begin
        hit = 1'b1;
        rd_val[`GPO_F_LEVEL] = in_level[j];
        rd_val[`GPO_F_PIN +: SEL_W] = in_pin_sel[j];
        rd_val[`GPO_F_INDEX +: 4] = 4'(j);
        rd_val[`GPO_F_TYPE +: 4] = `GPO_TYPE_IN;
      end
    end
    if (paddr == `GPO_TRIG) begin
      hit = 1'b1;
      rd_val[NUM_OUT-1:0] = active;
    end
    if (paddr == `GPO_INT_STAT) begin
      hit = 1'b1;
      rd_val[EV_W-1:0] = int_stat;
    end
    if (paddr == `GPO_INT_MASK) begin
      hit = 1'b1;
      rd_val[EV_W-1:0] = int_mask;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else if (ce) begin
      pready <= setup;
      // Error is shown only beside pready, never left standing after it
      pslverr <= setup && !hit;
      if (setup) begin
        prdata <= pwrite ? '0 : rd_val;
      end
    end
  end

  // ==========================================================
  // Configuration registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_OUT; i++) begin
        hold_ms[i] <= `GPO_RST_HOLD;
        rest_level[i] <= `GPO_RST_REST;
        report_en[i] <= `GPO_RST_REPORT;
        out_pin_sel[i] <= SEL_W'(i);
      end
      for (int j = 0; j < NUM_IN; j++) begin
        in_pin_sel[j] <= SEL_W'(NUM_PINS - 1 - j);
      end
      int_mask <= '0;
    end else if (ce && wr) begin
      for (int i = 0; i < NUM_OUT; i++) begin
        if (paddr == `GPO_OUT_CFG_BASE + 8'(4 * i)) begin
          hold_ms[i] <= pwdata[`GPO_F_HOLD +: 16];
          rest_level[i] <= pwdata[`GPO_F_REST];
          report_en[i] <= pwdata[`GPO_F_REPORT];
          out_pin_sel[i] <= pwdata[`GPO_F_PIN +: SEL_W];
        end
      end
      for (int j = 0; j < NUM_IN; j++) begin
        if (paddr == `GPO_IN_CFG_BASE + 8'(4 * j)) begin
          in_pin_sel[j] <= pwdata[`GPO_F_PIN +: SEL_W];
        end
      end
      if (paddr == `GPO_INT_MASK) begin
        int_mask <= pwdata[EV_W-1:0];
      end
    end
  end

  // Software trigger lasts one cycle whatever is written
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sw_trig <= '0;
    end else if (ce) begin
      sw_trig <= (wr && paddr == `GPO_TRIG) ? pwdata[NUM_OUT-1:0] : '0;
    end
  end

  // ==========================================================
  // Events and interrupt
  assign w1c = (wr && paddr == `GPO_INT_STAT) ? pwdata[EV_W-1:0] : '0;

  always_comb begin
    ev_all = '0;
    for (int i = 0; i < NUM_OUT; i++) begin
      ev_all[i] = changed[i] && report_en[i];
    end
    for (int j = 0; j < NUM_IN; j++) begin
      ev_all[NUM_OUT + j] = in_sample[j] != in_level[j];
    end
  end

  // A new event beats a clear in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      int_stat <= '0;
      irq <= 1'b0;
    end else if (ce) begin
      int_stat <= (int_stat & ~w1c) | ev_all;
      irq <= |(int_stat & int_mask);
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_tick_wrap: assert property (
    ce && ms_tick |=> tick_cnt == '0)
    else $error("millisecond counter did not wrap");
  a_edge_single: assert property (
    ce && trig_edge[0] |=> !trig_edge[0])
    else $error("trigger edge lasted more than one cycle");
  a_pin_level: assert property (
    ce |=> pin_out[$past(out_pin_sel[0])] == $past(lvl[0]))
    else $error("pin level differs from channel level");
  a_pin_driven: assert property (
    ce |=> !pin_oe_n[$past(out_pin_sel[0])])
    else $error("output channel pin not driven");
  a_in_status: assert property (
    ce |=> in_level == $past(in_sample))
    else $error("input status does not follow pin");
  a_event_set: assert property (
    ce && ev_all[0] |=> int_stat[0])
    else $error("change event lost");
  a_irq_level: assert property (
    ce |=> irq == |($past(int_stat) & $past(int_mask)))
    else $error("interrupt does not follow masked status");

  // ==========================================================
  // Bus, timebase, pin and event checks
  // A stalled clock enable must leave pin_out, irq and prdata where they were
  a_ce_freeze: assert property (
    !ce |=> $stable(pin_out) && $stable(irq) && $stable(prdata))
    else $error("outputs moved while clock enable was low");
  a_ready_setup: assert property (
    ce && setup |=> pready)
    else $error("no ready after setup cycle");
  a_ready_once: assert property (
    ce && pready |=> !pready)
    else $error("ready stood longer than one cycle");
  a_ready_idle: assert property (
    ce && !psel |=> !pready)
    else $error("ready without a selected transfer");
  a_err_ready: assert property (
    pslverr |-> pready)
    else $error("error shown without ready");
  a_mask_write: assert property (
    ce && wr && paddr == `GPO_INT_MASK
    |=> int_mask == $past(pwdata[EV_W-1:0]))
    else $error("mask write did not land");
  a_sw_pulse: assert property (
    ce && sw_trig[0] |=> !sw_trig[0])
    else $error("software trigger lasted more than one cycle");
  a_tick_count: assert property (
    ce && !ms_tick |=> tick_cnt == $past(tick_cnt) + 1'b1)
    else $error("millisecond counter skipped a cycle");
  a_pin_driven_one: assert property (
    ce |=> !pin_oe_n[$past(out_pin_sel[1])])
    else $error("second output channel pin not driven");
  a_event_one: assert property (
    ce && ev_all[1] |=> int_stat[1])
    else $error("second channel change event lost");
  a_in_event: assert property (
    ce && ev_all[NUM_OUT] |=> int_stat[NUM_OUT])
    else $error("input change event lost");
  a_stat_sticky: assert property (
    ce && int_stat[0] && !w1c[0] |=> int_stat[0])
    else $error("status bit dropped without a clear");
  a_stat_clear: assert property (
    ce && w1c[0] && !ev_all[0] |=> !int_stat[0])
    else $error("status bit survived a clear");
  a_irq_quiet: assert property (
    ce && int_mask == '0 |=> !irq)
    else $error("interrupt raised with every source masked");

endmodule : gpo_top

// >>> gpo_defs.svh
`ifndef GPO_DEFS_SVH
`define GPO_DEFS_SVH

// ==========================================================
// Timing
`define GPO_CLK_PERIOD_NS 5
`define GPO_MS_NS 1000000
`define GPO_MS_CYCLES (`GPO_MS_NS / `GPO_CLK_PERIOD_NS)

// ==========================================================
// Register byte addresses
`define GPO_OUT_CFG_BASE 8'h00
`define GPO_IN_CFG_BASE 8'h10
`define GPO_TRIG 8'h20
`define GPO_INT_STAT 8'h24
`define GPO_INT_MASK 8'h28

// ==========================================================
// Field positions
`define GPO_F_HOLD 0
`define GPO_F_LEVEL 8
`define GPO_F_REST 16
`define GPO_F_REPORT 17
`define GPO_F_PIN 20
`define GPO_F_INDEX 24
`define GPO_F_TYPE 28

// ==========================================================
// Type codes and reset values
`define GPO_TYPE_OUT 4'h1
`define GPO_TYPE_IN 4'h2
`define GPO_RST_HOLD 16'h000a
`define GPO_RST_REST 1'b0
`define GPO_RST_REPORT 1'b1

`endif

// >>> gpo_pkg.sv
package gpo_pkg;

  // ==========================================================
  // Output channel states
  typedef enum logic [1:0] {
    GPO_ST_IDLE = 2'b01,
    GPO_ST_ACT = 2'b10
  } gpo_state_t;

endpackage : gpo_pkg

// >>> gpo_channel.sv
`timescale 1ns/1ps
module gpo_channel #(
  parameter int HOLD_W = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic ms_tick,
  input wire logic trig,
  input wire logic [HOLD_W-1:0] hold_ms,
  output gpo_pkg::gpo_state_t state,
  output logic active,
  output logic changed
);
  import gpo_pkg::*;

  logic [HOLD_W-1:0] ms_cnt;
  logic prev_active;

  // ==========================================================
  // State machine
  // Leaves on tick hold+1: the first tick may land at once, so the
  // pulse is at most one millisecond longer than hold_ms but never short
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= GPO_ST_IDLE;
      ms_cnt <= '0;
    end else if (ce) begin
      case (state)
        GPO_ST_IDLE: begin
          if (trig) begin
            state <= GPO_ST_ACT;
            ms_cnt <= '0;
          end
        end
        GPO_ST_ACT: begin
          if (hold_ms == '0) begin
            if (trig) begin
              state <= GPO_ST_IDLE;
            end
          end else if (ms_tick) begin
            if (ms_cnt >= hold_ms) begin
              state <= GPO_ST_IDLE;
            end else begin
              ms_cnt <= ms_cnt + 1'b1;
            end
          end
        end
        default: state <= GPO_ST_IDLE;
      endcase
    end
  end

  assign active = (state == GPO_ST_ACT);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_active <= 1'b0;
    end else if (ce) begin
      prev_active <= active;
    end
  end

  assign changed = active ^ prev_active;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_idle_stays: assert property (
    ce && state == GPO_ST_IDLE && !trig |=> state == GPO_ST_IDLE)
    else $error("idle channel left idle without trigger");
  a_toggle_flip: assert property (
    ce && hold_ms == '0 && trig |=> state != $past(state))
    else $error("zero hold trigger did not toggle");
  a_not_short: assert property (
    ce && active && hold_ms != '0 && ms_cnt < hold_ms |=> active)
    else $error("pulse ended before hold time");
  a_pulse_end: assert property (
    ce && active && hold_ms != '0 && ms_tick && ms_cnt >= hold_ms
    |=> !active)
    else $error("pulse did not end after hold time");
  a_no_retrig: assert property (
    ce && active && hold_ms != '0 && trig && !ms_tick
    |=> active && ms_cnt == $past(ms_cnt))
    else $error("trigger restarted a running pulse");

endmodule : gpo_channel

// >>> gpo_pins_model.sv
`timescale 1ns/1ps
// ==========================================================
// Board model: an LED on pin 0, switches and buttons
module gpo_pins_model #(
  parameter int NP = 4
) (
  input wire logic clk,
  input wire logic [NP-1:0] pin_out,
  input wire logic [NP-1:0] pin_oe_n,
  input wire logic [NP-1:0] sw,
  input wire logic [1:0] press,
  output logic [1:0] trig_in,
  output logic [NP-1:0] pin_in,
  output logic [7:0] led_pulses
);
  logic led_q;
  // Buttons are momentary: high only while pressed
  assign trig_in = press;
  // A driven pin follows the driver; a free pin follows its switch
  // A pin may be both driven and read; reading it then gives the driven level
  always_comb begin
    for (int i = 0; i < NP; i++) begin
      pin_in[i] = pin_oe_n[i] ? sw[i] : pin_out[i];
    end
  end
  // Counts rising edges seen on the LED of pin 0
  initial led_pulses = 8'h00;
  initial led_q = 1'b0;
  always @(posedge clk) begin
    led_q <= pin_in[0];
    if (pin_in[0] && !led_q) begin
      led_pulses <= led_pulses + 8'h01;
    end
  end
endmodule : gpo_pins_model

// >>> tb_gpio_pulse_output.sv
`timescale 1ns/1ps
// ==========================================================
// Bench
module tb_gpio_pulse_output;
  localparam int TK = 20;
  logic clk, rst, ce, psel, penable, pwrite, pready, pslverr, irq, er;
  logic [7:0] paddr, led_pulses;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] press, trig_in;
  logic [3:0] sw, pin_in, pin_out, pin_oe_n;
  int fail_count = 0;
  int samples_checked = 0;
  int n;

  gpo_top #(.TICK_CYCLES(TK)) i_gpo_top (.clk(clk), .rst(rst), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .trig_in(trig_in), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .irq(irq));
  gpo_pins_model i_gpo_pins_model (.clk(clk), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .sw(sw), .press(press), .trig_in(trig_in),
    .pin_in(pin_in), .led_pulses(led_pulses));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ==========================================================
  // Tasks
  task automatic results;
    if (fail_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask : cyc

  // Holds the request until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) begin
      chk("pready_wait", 32'h1, 32'h0);
      results();
    end
  endtask : apb

  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd & m);
  endtask : rchk

  task automatic wait_pin(input int i, input logic v, input int lim);
    int k;
    k = 0;
    while (pin_out[i] !== v && k < lim) begin
      @(posedge clk);
      k++;
    end
    if (k >= lim) begin
      chk("pin_wait", 32'h1, 32'h0);
      results();
    end
  endtask : wait_pin

  task automatic push(input int i);
    @(posedge clk);
    press[i] <= 1'b1;
    cyc(3);
    press[i] <= 1'b0;
  endtask : push

  // ==========================================================
  // Sequence
  initial begin
    rst = 1'b1; ce = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; press = 2'b00; sw = 4'h0;
    cyc(5);
    rst <= 1'b0;
    cyc(2);
    chk("pin_out", 32'h0, {28'h0, pin_out});
    chk("pin_oe_n", 32'hc, {28'h0, pin_oe_n});
    rchk("out0", 8'h00, 32'h1002000a, 32'hffffffff);
    rchk("out1", 8'h04, 32'h1112000a, 32'hffffffff);
    rchk("in0", 8'h10, 32'h20300000, 32'hffffffff);
    rchk("in1", 8'h14, 32'h21200000, 32'hffffffff);
    rchk("mask", 8'h28, 32'h0, 32'hffffffff);
    apb(1'b0, 8'h2c, 32'h0);
    chk("bad_rd", 32'h0, rd);
    chk("bad_err", 32'h1, {31'h0, er});
    // Pulsed channel 0, 2 ms, driven by the button
    apb(1'b1, 8'h00, 32'h00020002);
    push(0);
    wait_pin(0, 1'b1, 10);
    // A second press during the pulse must neither restart nor stretch it
    push(0);
    n = 0;
    while (pin_out[0] === 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    // Counting starts four edges after the pin went active
    chk("len_ok", 32'h1, {31'h0, n + 4 >= 2 * TK && n + 4 <= 3 * TK});
    cyc(4 * TK);
    chk("pulses", 32'h1, {24'h0, led_pulses});
    // Rest high: active level must be low
    apb(1'b1, 8'h00, 32'h00030002);
    cyc(3);
    chk("rest_hi", 32'h1, {31'h0, pin_out[0]});
    apb(1'b1, 8'h24, 32'hffffffff);
    apb(1'b1, 8'h28, 32'h1);
    cyc(2);
    chk("irq_off", 32'h0, {31'h0, irq});
    apb(1'b1, 8'h20, 32'h1);
    // Interrupt trails the status bit by one more cycle than the pin
    cyc(4);
    chk("act_lo", 32'h0, {31'h0, pin_out[0]});
    chk("irq_on", 32'h1, {31'h0, irq});
    rchk("stat0", 8'h24, 32'h1, 32'h1);
    wait_pin(0, 1'b1, 4 * TK);
    cyc(3);
    apb(1'b1, 8'h24, 32'h1);
    cyc(2);
    chk("irq_clr", 32'h0, {31'h0, irq});
    // Held channel 1, zero hold; its event is masked out
    apb(1'b1, 8'h04, 32'h00120000);
    apb(1'b1, 8'h20, 32'h2);
    cyc(3);
    chk("held_on", 32'h1, {31'h0, pin_out[1]});
    // A press while the clock enable is low is lost
    ce <= 1'b0;
    push(1);
    cyc(2);
    ce <= 1'b1;
    cyc(5 * TK);
    chk("held_stay", 32'h1, {31'h0, pin_out[1]});
    rchk("trig_rd", 8'h20, 32'h2, 32'h3);
    rchk("stat1", 8'h24, 32'h2, 32'h2);
    chk("irq_mask", 32'h0, {31'h0, irq});
    push(1);
    cyc(3);
    chk("held_off", 32'h0, {31'h0, pin_out[1]});
    // Input channel 0 watches free pin 3
    sw <= 4'h8;
    cyc(3);
    rchk("in_lvl", 8'h10, 32'h100, 32'h100);
    rchk("in_evt", 8'h24, 32'h4, 32'h4);
    results();
  end
endmodule : tb_gpio_pulse_output
